//--- logic/wfjs_consts.svh
// register offsets, field positions, reset values and timing counts
`ifndef WFJS_CONSTS_SVH
`define WFJS_CONSTS_SVH
`define WFJS_OFF_WAKE_DATA 8'h70
`define WFJS_OFF_WDOG_CTRL 8'h78
`define WFJS_OFF_SEC_STATUS 8'h80
`define WFJS_OFF_IRQ_MASK 8'h88
`define WFJS_WDOG_RESET 6'h00
`define WFJS_BIT_JAB_DIS 0
`define WFJS_BIT_JAB_IMM 1
`define WFJS_BIT_JAB_SEL 2
`define WFJS_BIT_WDOG_DIS 4
`define WFJS_BIT_WDOG_REL 5
`define WFJS_BIT_TX_EARLY 31
`define WFJS_BIT_RX_EARLY 30
`define WFJS_BIT_XCVR 29
`define WFJS_BIT_TX_DEFER 28
`define WFJS_BIT_PAUSE 26
`define WFJS_STICKY_MASK 32'hd4000000
`define WFJS_WAKE_WORDS 25
`define WFJS_RX_WDOG_BYTES 2560
`define WFJS_REL_SHORT_BITS 24
`define WFJS_REL_LONG_BITS 48
`define WFJS_JAB_BYTE_TIMES 2560
`define WFJS_CLK_MHZ 200
`define WFJS_JAB_CUT_US_100 2600
`define WFJS_JAB_CUT_US_10 26000
`define WFJS_JAB_WAIT_US_100 42000
`define WFJS_JAB_WAIT_US_10 420000
`define WFJS_BUS_ERR_PARITY 3'h0
`define WFJS_BUS_ERR_MASTER 3'h1
`define WFJS_BUS_ERR_TARGET 3'h2
`endif

//--- logic/wfjs_pkg.sv
// types shared by the wake filter, jabber and status register block
package wfjs_pkg;
    typedef enum logic [1:0] {
        WFJS_JAB_IDLE = 2'b01,
        WFJS_JAB_BLOCK = 2'b10
    } wfjs_jab_e;
    typedef logic [7:0] wfjs_idx_t;
endpackage

//--- logic/wfjs_regs.sv
// wake pattern store, watchdog and jabber timers, secondary status register
//
// Behaviour
// - each of five patterns is four mask words then crc and offset word.
// - release control picks 24 or 48 bit-times from carrier drop to release.
// - watchdog expires past 2560 received bytes unless disabled.
// - jabber select: 2.6/26 ms cutoff, or 2560 byte times.
// - after jabber expiry re-enable at once, or after 42/420 ms.
// - bit 0 disables jabber; all control fields reset to zero.
// - tx early flag bit 31 set when enabled and packet moved to fifo.
// - rx early flag bit 30 set when enabled and first descriptor filled.
// - early flags latch high and clear by writing one.
// - transceiver flag bit 29 is OR of source register bits 6 to 0.
// - pause flag bit 26 set when pause frame received with pause enabled.
// - bus error kind in bits 25:23, meaningful with fatal error, no interrupt.
// - bits 14:0 mirror primary status, clearable through either address.
`timescale 1ns/1ps
`include "wfjs_consts.svh"
module wfjs_regs
    import wfjs_pkg::*;
#(
    parameter int JAB_CUT_100 = `WFJS_JAB_CUT_US_100 * `WFJS_CLK_MHZ,
    parameter int JAB_CUT_10 = `WFJS_JAB_CUT_US_10 * `WFJS_CLK_MHZ,
    parameter int JAB_WAIT_100 = `WFJS_JAB_WAIT_US_100 * `WFJS_CLK_MHZ,
    parameter int JAB_WAIT_10 = `WFJS_JAB_WAIT_US_10 * `WFJS_CLK_MHZ
) (
    // clock and reset
    input wire logic sys_clk,
    input wire logic nrst,
    // axi4-lite slave
    input wire logic [7:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [7:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    // enables held in the secondary enable register
    input wire logic tx_early_enable,
    input wire logic rx_early_enable,
    input wire logic pause_enable,
    // event pulses from mac and dma
    input wire logic tx_pkt_to_fifo,
    input wire logic rx_first_desc_full,
    input wire logic tx_deferred_evt,
    input wire logic pause_frame_rx,
    input wire logic [6:0] transceiver_irq_source_reg,
    input wire logic [2:0] bus_err_code,
    input wire logic bus_err_evt,
    // primary status mirror
    input wire logic [14:0] primary_status_reg,
    output logic [14:0] primary_clear,
    // link timing
    input wire logic speed_100,
    input wire logic bit_tick,
    input wire logic byte_tick,
    input wire logic rx_active,
    input wire logic rx_byte,
    input wire logic carrier,
    input wire logic tx_active,
    // watchdog and jabber outputs
    output logic rx_wdog_expired,
    output logic tx_jabber_block,
    // wake pattern write port and interrupt line
    output logic wake_we,
    output logic [4:0] wake_addr,
    output logic [31:0] wake_wdata,
    output logic irq
);
    logic [5:0] wdog_ctrl;
    logic [31:0] sticky;
    logic [31:0] irq_mask;
    logic [2:0] bus_error_kind;
    logic aw_held, w_held;
    logic [7:0] aw_q;
    logic [31:0] w_q;
    wfjs_idx_t wake_idx;
    logic [31:0] wake_mem [0:`WFJS_WAKE_WORDS-1];
    logic [11:0] rx_bytes;
    logic [5:0] rel_bits;
    logic carrier_q;
    logic releasing;
    logic [31:0] jab_cnt;
    wfjs_jab_e jab_state;
    logic do_write;
    logic [7:0] wr_addr;
    logic [31:0] wr_data;
    logic [31:0] w1c;
    logic [31:0] next_sticky;
    logic [31:0] read_word;
    logic [31:0] jab_limit;
    logic [31:0] wait_limit;

    // write address and data accepted in either order
    assign do_write = (aw_held | s_axi_awvalid) & (w_held | s_axi_wvalid) & ~s_axi_bvalid;
    assign wr_addr = aw_held ? aw_q : s_axi_awaddr;
    assign wr_data = w_held ? w_q : s_axi_wdata;
    always_ff @(posedge sys_clk or negedge nrst) begin
        if (!nrst) begin
            aw_held <= 1'b0;
            w_held <= 1'b0;
            aw_q <= 8'h00;
            w_q <= 32'h0;
            s_axi_awready <= 1'b0;
            s_axi_wready <= 1'b0;
            s_axi_bvalid <= 1'b0;
            s_axi_bresp <= 2'h0;
        end else begin
            s_axi_awready <= 1'b0;
            s_axi_wready <= 1'b0;
            if (s_axi_bvalid && s_axi_bready) begin
                s_axi_bvalid <= 1'b0;
            end
            if (do_write && !(s_axi_awready || s_axi_wready)) begin
                s_axi_awready <= ~aw_held;
                s_axi_wready <= ~w_held;
                aw_held <= 1'b0;
                w_held <= 1'b0;
                s_axi_bvalid <= 1'b1;
                s_axi_bresp <= (wr_addr == `WFJS_OFF_WAKE_DATA || wr_addr == `WFJS_OFF_WDOG_CTRL ||
                    wr_addr == `WFJS_OFF_SEC_STATUS || wr_addr == `WFJS_OFF_IRQ_MASK) ? 2'h0 : 2'h2;
            end else if (!s_axi_awready && !s_axi_wready) begin
                if (s_axi_awvalid && !aw_held && !do_write) begin
                    aw_held <= 1'b1;
                    aw_q <= s_axi_awaddr;
                    s_axi_awready <= 1'b1;
                end
                if (s_axi_wvalid && !w_held && !do_write) begin
                    w_held <= 1'b1;
                    w_q <= s_axi_wdata;
                    s_axi_wready <= 1'b1;
                end
            end
        end
    end

    // a write commits in the cycle it is accepted
    logic commit;
    assign commit = do_write && !(s_axi_awready || s_axi_wready);

    // watchdog and jabber control register and interrupt mask register
    always_ff @(posedge sys_clk or negedge nrst) begin
        if (!nrst) begin
            wdog_ctrl <= `WFJS_WDOG_RESET;
            irq_mask <= 32'h0;
        end else if (commit && wr_addr == `WFJS_OFF_WDOG_CTRL) begin
            wdog_ctrl <= {wr_data[5:4] & {2{s_axi_wstrb[0]}}, 1'b0, wr_data[2:0] & {3{s_axi_wstrb[0]}}};
        end else if (commit && wr_addr == `WFJS_OFF_IRQ_MASK) begin
            irq_mask <= wr_data & (`WFJS_STICKY_MASK | 32'h20000000); // sticky bits plus transceiver bit
        end
    end

    // wake pattern store, index wraps after the last word
    always_ff @(posedge sys_clk or negedge nrst) begin
        if (!nrst) begin
            wake_idx <= 8'h00;
            wake_we <= 1'b0;
            wake_addr <= 5'h00;
            wake_wdata <= 32'h0;
        end else begin
            wake_we <= 1'b0;
            if (commit && wr_addr == `WFJS_OFF_WAKE_DATA) begin
                wake_mem[wake_idx[4:0]] <= wr_data;
                wake_we <= 1'b1;
                wake_addr <= wake_idx[4:0];
                wake_wdata <= wr_data;
                wake_idx <= (wake_idx == 8'(`WFJS_WAKE_WORDS - 1)) ? 8'h00 : wake_idx + 8'h01;
            end
        end
    end

    // sticky flags, set wins over clear
    assign w1c = (commit && wr_addr == `WFJS_OFF_SEC_STATUS) ? wr_data : 32'h0;
    always_comb begin
        next_sticky = sticky & ~(w1c & `WFJS_STICKY_MASK);
        if (tx_early_enable && tx_pkt_to_fifo) next_sticky[`WFJS_BIT_TX_EARLY] = 1'b1;
        if (rx_early_enable && rx_first_desc_full) next_sticky[`WFJS_BIT_RX_EARLY] = 1'b1;
        if (tx_deferred_evt) next_sticky[`WFJS_BIT_TX_DEFER] = 1'b1;
        if (pause_enable && pause_frame_rx) next_sticky[`WFJS_BIT_PAUSE] = 1'b1;
    end
    always_ff @(posedge sys_clk or negedge nrst) begin
        if (!nrst) begin
            sticky <= 32'h0;
            bus_error_kind <= `WFJS_BUS_ERR_PARITY;
            primary_clear <= 15'h0;
            irq <= 1'b0;
        end else begin
            sticky <= next_sticky;
            if (bus_err_evt) bus_error_kind <= bus_err_code;
            primary_clear <= w1c[14:0];
            // a set mask bit holds its source off the interrupt line
            irq <= |(next_sticky & ~irq_mask) | ((|transceiver_irq_source_reg) & ~irq_mask[`WFJS_BIT_XCVR]);
        end
    end

    // read path; bus error kind feeds no interrupt
    always_comb begin
        read_word = 32'h0;
        unique case (s_axi_araddr)
            `WFJS_OFF_WDOG_CTRL: read_word = {26'h0, wdog_ctrl};
            `WFJS_OFF_IRQ_MASK: read_word = irq_mask;
            `WFJS_OFF_SEC_STATUS: begin
                read_word = sticky;
                read_word[`WFJS_BIT_XCVR] = |transceiver_irq_source_reg;
                read_word[25:23] = bus_error_kind;
                read_word[14:0] = primary_status_reg;
            end
            default: read_word = 32'h0;
        endcase
    end
    always_ff @(posedge sys_clk or negedge nrst) begin
        if (!nrst) begin
            s_axi_arready <= 1'b0;
            s_axi_rvalid <= 1'b0;
            s_axi_rdata <= 32'h0;
            s_axi_rresp <= 2'h0;
        end else begin
            s_axi_arready <= 1'b0;
            if (s_axi_rvalid && s_axi_rready) begin
                s_axi_rvalid <= 1'b0;
            end else if (s_axi_arvalid && !s_axi_rvalid && !s_axi_arready) begin
                s_axi_arready <= 1'b1;
                s_axi_rvalid <= 1'b1;
                s_axi_rdata <= read_word;
                s_axi_rresp <= (s_axi_araddr == `WFJS_OFF_WDOG_CTRL || s_axi_araddr == `WFJS_OFF_SEC_STATUS ||
                    s_axi_araddr == `WFJS_OFF_IRQ_MASK || s_axi_araddr == `WFJS_OFF_WAKE_DATA) ? 2'h0 : 2'h2;
            end
        end
    end

    // receive watchdog: byte count and release delay after carrier drop
    always_ff @(posedge sys_clk or negedge nrst) begin
        if (!nrst) begin
            rx_bytes <= 12'h0;
            rel_bits <= 6'h0;
            carrier_q <= 1'b0;
            releasing <= 1'b0;
            rx_wdog_expired <= 1'b0;
        end else begin
            carrier_q <= carrier;
            if (wdog_ctrl[`WFJS_BIT_WDOG_DIS]) begin
                rx_wdog_expired <= 1'b0;
                rx_bytes <= 12'h0;
                releasing <= 1'b0;
            end else begin
                if (rx_active && rx_byte && rx_bytes != 12'hfff) rx_bytes <= rx_bytes + 12'h1;
                if (rx_bytes >= 12'(`WFJS_RX_WDOG_BYTES)) rx_wdog_expired <= 1'b1;
                if (carrier_q && !carrier) begin
                    releasing <= 1'b1;
                    rel_bits <= 6'h0;
                end else if (releasing && bit_tick) begin
                    rel_bits <= rel_bits + 6'h1;
                    if (rel_bits + 6'h1 >= (wdog_ctrl[`WFJS_BIT_WDOG_REL] ? 6'(`WFJS_REL_LONG_BITS) :
                        6'(`WFJS_REL_SHORT_BITS))) begin
                        releasing <= 1'b0;
                        rx_wdog_expired <= 1'b0;
                        rx_bytes <= 12'h0;
                    end
                end
            end
        end
    end

    // transmit jabber timer
    assign jab_limit = wdog_ctrl[`WFJS_BIT_JAB_SEL] ? 32'(`WFJS_JAB_BYTE_TIMES) :
        (speed_100 ? 32'(JAB_CUT_100) : 32'(JAB_CUT_10));
    assign wait_limit = speed_100 ? 32'(JAB_WAIT_100) : 32'(JAB_WAIT_10);
    always_ff @(posedge sys_clk or negedge nrst) begin
        if (!nrst) begin
            jab_state <= WFJS_JAB_IDLE;
            jab_cnt <= 32'h0;
            tx_jabber_block <= 1'b0;
        end else if (wdog_ctrl[`WFJS_BIT_JAB_DIS]) begin
            jab_state <= WFJS_JAB_IDLE;
            jab_cnt <= 32'h0;
            tx_jabber_block <= 1'b0;
        end else begin
            unique case (jab_state)
                WFJS_JAB_IDLE: begin
                    if (!tx_active) begin
                        jab_cnt <= 32'h0;
                    end else if (!wdog_ctrl[`WFJS_BIT_JAB_SEL] || byte_tick) begin
                        jab_cnt <= jab_cnt + 32'h1;
                        if (jab_cnt + 32'h1 >= jab_limit) begin
                            jab_cnt <= 32'h0;
                            if (!wdog_ctrl[`WFJS_BIT_JAB_IMM]) begin
                                jab_state <= WFJS_JAB_BLOCK;
                                tx_jabber_block <= 1'b1;
                            end
                        end
                    end
                end
                WFJS_JAB_BLOCK: begin
                    jab_cnt <= jab_cnt + 32'h1;
                    if (jab_cnt + 32'h1 >= wait_limit || wdog_ctrl[`WFJS_BIT_JAB_IMM]) begin
                        jab_state <= WFJS_JAB_IDLE;
                        jab_cnt <= 32'h0;
                        tx_jabber_block <= 1'b0;
                    end
                end
            endcase
        end
    end
endmodule

//--- sim/tb_top.sv
// self-checking bench for the wake, jabber and status registers
`timescale 1ns/1ps
module tb_top;
    import wfjs_pkg::*;
    logic sys_clk = 1'h0, nrst = 1'h0;
    logic [7:0] s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00;
    logic [31:0] s_axi_wdata = 32'h0, rv, s_axi_rdata, wake_wdata;
    logic [3:0] s_axi_wstrb = 4'hf, evt = 4'h0;
    logic s_axi_awvalid = 1'h0, s_axi_wvalid = 1'h0, s_axi_bready = 1'h0, s_axi_arvalid = 1'h0;
    logic s_axi_rready = 1'h0, tx_early_enable = 1'h0, rx_early_enable = 1'h0, pause_enable = 1'h0;
    logic bus_err_evt = 1'h0, speed_100 = 1'h1, bit_tick = 1'h0, byte_tick = 1'h0, rx_active = 1'h0;
    logic rx_byte = 1'h0, carrier = 1'h0, tx_active = 1'h0;
    logic [6:0] transceiver_irq_source_reg = 7'h00;
    logic [2:0] bus_err_code = 3'h0;
    logic [14:0] primary_status_reg = 15'h0000, primary_clear, clr = 15'h0000;
    logic [4:0] wake_addr, widx = 5'h00;
    logic [1:0] s_axi_bresp, s_axi_rresp, rs;
    logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
    logic rx_wdog_expired, tx_jabber_block, wake_we, irq;
    wire tx_pkt_to_fifo = evt[3], rx_first_desc_full = evt[2], tx_deferred_evt = evt[1], pause_frame_rx = evt[0];
    int fails = 0, n_tests = 0, wn = 0;
    // sticky flags: tx early, rx early, deferred, pause
    logic [31:0] sb [4] = '{32'h80000000, 32'h40000000, 32'h10000000, 32'h04000000};
    // short jabber counts keep the run brief
    wfjs_regs #(.JAB_CUT_100(50), .JAB_CUT_10(100), .JAB_WAIT_100(200), .JAB_WAIT_10(400)) wfjs_regs_inst (.*);
    initial begin
        forever #2.5 sys_clk = ~sys_clk;
    end
    task automatic report_and_stop();
        $display("comparisons %0d mismatches %0d", n_tests, fails);
        if (fails == 0 && n_tests > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask
    task automatic cmp(input logic [31:0] got, input logic [31:0] exp);
        n_tests++;
        if (got !== exp) begin
            fails++;
            $display("[ERR] %0t got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic cmp_rs(input logic [1:0] got, input logic [1:0] exp);
        cmp({30'h0, got}, {30'h0, exp});
    endtask
    task automatic tick(input int n);
        repeat (n) @(posedge sys_clk);
    endtask
    // one axi-lite transfer, write or read, bounded wait for the response
    task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
        logic done;
        done = 1'h0;
        @(posedge sys_clk);
        if (w) {s_axi_awaddr, s_axi_wdata, s_axi_awvalid, s_axi_wvalid} <= {a, d, 2'h3};
        else {s_axi_araddr, s_axi_arvalid} <= {a, 1'h1};
        {s_axi_bready, s_axi_rready} <= {w, !w};
        for (int i = 0; i < 64 && !done; i++) begin
            @(posedge sys_clk);
            if (s_axi_awready) s_axi_awvalid <= 1'h0;
            if (s_axi_wready) s_axi_wvalid <= 1'h0;
            if (s_axi_arready) s_axi_arvalid <= 1'h0;
            if (w ? s_axi_bvalid : s_axi_rvalid) begin
                rv = s_axi_rdata;
                rs = w ? s_axi_bresp : s_axi_rresp;
                done = 1'h1;
            end
        end
        {s_axi_bready, s_axi_rready} <= 2'h0;
        if (!done) begin
            fails++;
            $display("[ERR] %0t bus wait ran out, got %h expected %h", $time, 1'h0, 1'h1);
            report_and_stop();
        end
    endtask
    task automatic rdc(input logic [7:0] a, input logic [31:0] e);
        bus(1'h0, a, 32'h0);
        cmp(rv, e);
    endtask
    // after n cycles compare irq, jabber block or watchdog expiry
    task automatic pin(input int n, input int s, input logic e);
        logic [2:0] v;
        tick(n);
        v = {rx_wdog_expired, tx_jabber_block, irq};
        cmp({31'h0, v[s]}, {31'h0, e});
    endtask
    task automatic fire(input int k, input logic en);
        {tx_early_enable, rx_early_enable, pause_enable} <= {3{en}};
        evt <= 4'(4'h8 >> k);
        tick(1);
        evt <= 4'h0;
        tick(2);
    endtask
    // pattern words land in order and the index wraps
    always @(posedge sys_clk) begin
        if (wake_we) begin
            cmp({27'h0, wake_addr}, {27'h0, widx});
            cmp(wake_wdata, 32'ha5000000 + 32'(wn));
            widx <= (widx == 5'h18) ? 5'h00 : widx + 5'h01;
            wn <= wn + 1;
        end
        if (primary_clear !== 15'h0000) clr <= primary_clear;
    end
    initial begin
        tick(2);
        nrst <= 1'h1;
        rdc(8'h78, 32'h0);
        rdc(8'h80, 32'h0);
        pin(0, 0, 1'h0);
        bus(1'h1, 8'h78, 32'h36);
        rdc(8'h78, 32'h36);
        bus(1'h1, 8'h78, 32'h0);
        for (int i = 0; i < 26; i++) bus(1'h1, 8'h70, 32'ha5000000 + 32'(i));
        tick(3);
        cmp(32'(wn), 32'h1a);
        rdc(8'h70, 32'h0);
        bus(1'h1, 8'h90, 32'hffffffff);
        cmp_rs(rs, 2'h2);
        bus(1'h0, 8'h90, 32'h0);
        cmp_rs(rs, 2'h2);
        $display("control, pattern and unmapped tests done");
        bus(1'h1, 8'h88, 32'h0);
        for (int k = 0; k < 4; k++) begin
            fire(k, 1'h0);
            rdc(8'h80, (k == 2) ? sb[k] : 32'h0);
            bus(1'h1, 8'h80, sb[k]);
            fire(k, 1'h1);
            rdc(8'h80, sb[k]);
            pin(0, 0, 1'h1);
            bus(1'h1, 8'h88, sb[k]);
            pin(2, 0, 1'h0);
            bus(1'h1, 8'h88, 32'h0);
            pin(2, 0, 1'h1);
            bus(1'h1, 8'h80, sb[k]);
            rdc(8'h80, 32'h0);
            pin(0, 0, 1'h0);
        end
        $display("sticky flag test done");
        transceiver_irq_source_reg <= 7'h40;
        rdc(8'h80, 32'h20000000);
        pin(0, 0, 1'h1);
        transceiver_irq_source_reg <= 7'h00;
        rdc(8'h80, 32'h0);
        for (int c = 0; c < 3; c++) begin
            {bus_err_code, bus_err_evt} <= {3'(c), 1'h1};
            tick(1);
            bus_err_evt <= 1'h0;
            rdc(8'h80, 32'(c) << 23);
            pin(0, 0, 1'h0);
        end
        primary_status_reg <= 15'h2a5a;
        rdc(8'h80, 32'h01002a5a);
        bus(1'h1, 8'h80, 32'h3);
        tick(2);
        cmp({17'h0, clr}, 32'h3);
        $display("transceiver, bus error and mirror tests done");
        for (int s = 0; s < 2; s++) begin
            {speed_100, tx_active} <= {s == 0, 1'h1};
            pin(40 + 50 * s, 1, 1'h0);
            pin(20, 1, 1'h1);
            tx_active <= 1'h0;
            pin(100 + 100 * s, 1, 1'h1);
            pin(200 + 200 * s, 1, 1'h0);
        end
        speed_100 <= 1'h1;
        bus(1'h1, 8'h78, 32'h2);
        tx_active <= 1'h1;
        pin(150, 1, 1'h0);
        bus(1'h1, 8'h78, 32'h1);
        pin(150, 1, 1'h0);
        tx_active <= 1'h0;
        bus(1'h1, 8'h78, 32'h4);
        {tx_active, byte_tick} <= 2'h3;
        pin(2540, 1, 1'h0);
        pin(40, 1, 1'h1);
        {tx_active, byte_tick} <= 2'h0;
        pin(300, 1, 1'h0);
        $display("jabber test done");
        for (int r = 0; r < 3; r++) begin
            bus(1'h1, 8'h78, (r == 2) ? 32'h10 : 32'(r) << 5);
            {carrier, rx_active, rx_byte, byte_tick} <= 4'hf;
            pin(2550, 2, 1'h0);
            pin(20, 2, r < 2);
            {carrier, rx_active, rx_byte, byte_tick, bit_tick} <= 5'h01;
            pin((r == 1) ? 44 : 20, 2, r < 2);
            pin(10, 2, 1'h0);
            bit_tick <= 1'h0;
        end
        $display("watchdog test done");
        report_and_stop();
    end
endmodule

//--- sim/wfjs_regs_assertions.sv
// concurrent checks on the wake, jabber and status register block
`timescale 1ns/1ps
module wfjs_regs_chk
    import wfjs_pkg::*;
(
    // clock, reset and bus
    input wire logic sys_clk, nrst, s_axi_awready, s_axi_bvalid, s_axi_bready,
    input wire logic s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready,
    input wire logic [7:0] s_axi_awaddr, s_axi_araddr,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [1:0] s_axi_bresp, s_axi_rresp,
    // timers and pattern port
    input wire logic rx_wdog_expired, tx_jabber_block, wake_we,
    input wire logic [4:0] wake_addr
);
    logic [5:0] ctl;
    logic [4:0] last;
    // control word as the bus writes it
    always_ff @(posedge sys_clk or negedge nrst) begin
        if (!nrst) ctl <= 6'h00;
        else if (s_axi_awready && s_axi_awaddr == 8'h78) ctl <= s_axi_wdata[5:0];
    end
    // last pattern index, primed so the first expected is zero
    always_ff @(posedge sys_clk or negedge nrst) begin
        if (!nrst) last <= 5'h18;
        else if (wake_we) last <= wake_addr;
    end
    default clocking @(posedge sys_clk); endclocking
    default disable iff (!nrst);
    sequence s_ctl_wr; s_axi_awready && s_axi_awaddr == 8'h78; endsequence
    sequence s_bad_rd; s_axi_arready && !(s_axi_araddr inside {8'h70, 8'h78, 8'h80, 8'h88}); endsequence
    property p_wake_step; wake_we |-> wake_addr == ((last == 5'h18) ? 5'h00 : last + 5'h01); endproperty
    a_wake_step: assert property (p_wake_step) else $error("pattern word index skipped");
    property p_jab_off; ctl[0] && !tx_jabber_block |=> !tx_jabber_block; endproperty
    a_jab_off: assert property (p_jab_off) else $error("jabber blocked while disabled");
    property p_jab_imm; ctl[1] && !ctl[0] && !tx_jabber_block |=> !tx_jabber_block; endproperty
    a_jab_imm: assert property (p_jab_imm) else $error("jabber blocked with immediate re-enable");
    property p_wdog_off; ctl[4] && !rx_wdog_expired |=> !rx_wdog_expired; endproperty
    a_wdog_off: assert property (p_wdog_off) else $error("watchdog expired while disabled");
    property p_ctl_ok; s_ctl_wr |-> s_axi_bvalid && s_axi_bresp == 2'h0; endproperty
    a_ctl_ok: assert property (p_ctl_ok) else $error("control write not answered okay");
    property p_bad_rd; s_bad_rd |-> s_axi_rvalid && s_axi_rresp == 2'h2; endproperty
    a_bad_rd: assert property (p_bad_rd) else $error("unmapped read not refused");
    property p_b_once; s_axi_bvalid && s_axi_bready |=> !s_axi_bvalid; endproperty
    a_b_once: assert property (p_b_once) else $error("write response repeated");
    property p_r_once; s_axi_rvalid && s_axi_rready |=> !s_axi_rvalid; endproperty
    a_r_once: assert property (p_r_once) else $error("read response repeated");
endmodule
bind wfjs_regs wfjs_regs_chk wfjs_regs_chk_inst (.*);
